// [sim/serial_flash_pin_interface_test.sv]
// Self-checking bench for the serial flash pin front end
module serial_flash_pin_interface_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic csN, sck, si, soOut, soOe, rdyBusyOut, rdyBusyOe, cmdStrobe, cmdRejected, arrayDenied;
   logic wpN = 1'b1;
   logic resetPinN = 1'b1;
   logic [7:0] cmdOpcode, rx;
   logic [7:0] txByte = 8'h00;
   logic [3:0] cmdSector = 4'h0;
   logic [15:0] protMapIn = 16'h0000;
   logic [15:0] protMap;
   logic sawStrobe = 1'b0;
   logic sawRej = 1'b0;
   logic sawDen = 1'b0;
   logic sawOe = 1'b0;
   logic ok;
   int errorCnt = 0;
   int nChecks = 0;
   always #2 clk_sys = ~clk_sys;
   sfp_front_end dut (.clk_sys(clk_sys), .arst_n(arst_n), .csN(csN), .sck(sck), .si(si), .soOut(soOut),
      .soOe(soOe), .wpN(wpN), .resetPinN(resetPinN), .rdyBusyOut(rdyBusyOut), .rdyBusyOe(rdyBusyOe),
      .cmdOpcode(cmdOpcode), .cmdStrobe(cmdStrobe), .cmdRejected(cmdRejected), .arrayDenied(arrayDenied),
      .txByte(txByte), .cmdSector(cmdSector), .protMapIn(protMapIn), .protMap(protMap));
   // Pull-up on the busy line: released means high
   sfp_host_model host (.clk_sys(clk_sys), .csN(csN), .sck(sck), .si(si), .soOut(soOut), .soOe(soOe),
      .rdyBusyN(~rdyBusyOe));
   // Strobes last one cycle, so latch them until a scenario clears them
   always @(posedge clk_sys)
   begin
      if (cmdStrobe)
         sawStrobe <= 1'b1;
      if (cmdRejected)
         sawRej <= 1'b1;
      if (arrayDenied)
         sawDen <= 1'b1;
      if (soOe)
         sawOe <= 1'b1;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      nChecks++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic clr();
      @(posedge clk_sys);
      sawStrobe <= 1'b0;
      sawRej <= 1'b0;
      sawDen <= 1'b0;
      sawOe <= 1'b0;
   endtask
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", nChecks, errorCnt);
      if (errorCnt == 0 && nChecks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_read();
      txByte <= 8'hA5;
      clr();
      host.frame(sfp_pkg::CMD_BUF2_READ, 1, rx);
      check(sawStrobe, 1'b1);
      check(cmdOpcode, sfp_pkg::CMD_BUF2_READ);
      check(rx, 8'hA5);
      check(soOe, 1'b0);
   endtask
   task automatic t_protect();
      wpN <= 1'b0;
      protMapIn <= 16'h00FF;
      clr();
      host.frame(sfp_pkg::CMD_PROT_WRITE, 2, rx);
      check(protMap, 16'h0000);
      host.frame(sfp_pkg::CMD_PROGRAM, 3, rx);
      check(sawRej, 1'b1);
      check(rdyBusyOe, 1'b0);
      clr();
      cmdSector <= 4'h3;
      host.frame(sfp_pkg::CMD_PROT_ARM, 0, rx);
      host.frame(sfp_pkg::CMD_LOCKDOWN, 0, rx);
      check(sawRej, 1'b0);
      check(cmdOpcode, sfp_pkg::CMD_LOCKDOWN);
      check(protMap, 16'h0008);
      wpN <= 1'b1;
      host.frame(sfp_pkg::CMD_PROT_WRITE, 2, rx);
      check(protMap, 16'h00FF);
   endtask
   task automatic t_busy();
      host.frame(sfp_pkg::CMD_ERASE, 3, rx);
      check(rdyBusyOe, 1'b1);
      check(rdyBusyOut, 1'b0);
      clr();
      host.frame(sfp_pkg::CMD_READ_ARRAY, 0, rx);
      check(sawDen, 1'b1);
      host.waitReady(ok);
      check(ok, 1'b1);
      host.frame(sfp_pkg::CMD_XFER, 3, rx);
      clr();
      host.frame(sfp_pkg::CMD_BUF1_READ, 1, rx);
      check(sawDen, 1'b0);
      check(sawOe, 1'b0);
      host.waitReady(ok);
      host.frame(sfp_pkg::CMD_COMPARE, 3, rx);
      clr();
      host.frame(sfp_pkg::CMD_BUF2_READ, 1, rx);
      check(sawDen, 1'b0);
      check(sawStrobe, 1'b1);
      check(sawOe, 1'b1);
      host.waitReady(ok);
   endtask
   task automatic t_reset();
      host.frame(sfp_pkg::CMD_PROGRAM, 3, rx);
      resetPinN <= 1'b0;
      host.waitClk(8);
      check(rdyBusyOe, 1'b0);
      check(protMap, 16'h0000);
      clr();
      host.frame(sfp_pkg::CMD_BUF2_READ, 0, rx);
      check(sawStrobe, 1'b0);
      resetPinN <= 1'b1;
      host.waitClk(8);
      host.frame(sfp_pkg::CMD_BUF2_READ, 0, rx);
      check(sawStrobe, 1'b1);
   endtask
   initial
   begin
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      t_read();
      t_protect();
      t_busy();
      t_reset();
      summarize();
   end
   // Whole run needs a few thousand cycles; this leaves ample margin
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      errorCnt++;
      summarize();
   end
endmodule

// [sim/sfp_host_model.sv]
// Host controller model that frames commands on the serial pins
module sfp_host_model
(
   input wire logic clk_sys,
   output logic csN,
   output logic sck,
   output logic si,
   input wire logic soOut,
   input wire logic soOe,
   input wire logic rdyBusyN
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rxSh;
   initial
   begin
      csN = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      rxSh = 8'h00;
   end
   // Deselected input line keeps moving so stale bits cannot pass
   always @(posedge clk_sys)
      if (csN)
         si <= ~si;
   task automatic waitClk(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Bit set while clock is low, stable across the rise; MSB first
   task automatic shiftByte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         si <= b[i];
         waitClk(4);
         sck <= 1'b1;
         waitClk(4);
         // A released output line reads as the inverse of its last value
         rxSh = {rxSh[6:0], soOe ? soOut : ~soOut};
         sck <= 1'b0;
      end
   endtask
   task automatic frame(input logic [7:0] op, input int nArg, output logic [7:0] rx);
      csN <= 1'b0;
      waitClk(4);
      shiftByte(op);
      repeat (nArg) shiftByte(8'h00);
      waitClk(8);
      rx = rxSh;
      csN <= 1'b1;
      waitClk(12);
   endtask
   // Bounded poll of the open-drain line before touching the array
   task automatic waitReady(output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 300 && !ok; i++)
      begin
         waitClk(1);
         ok = (rdyBusyN === 1'b1);
      end
   endtask
endmodule

// [verilog/sfp_busy_timer.sv]
// Self-timed operation timer driving the busy indication
module sfp_busy_timer
(
   input wire logic clk_sys,
   input wire logic rstN,
   input wire logic start,
   input wire logic [1:0] bufSel,
   output logic busy,
   output logic [1:0] busyBuf
);
   logic [15:0] cnt_q;
   logic [1:0] buf_q;

   always_ff @(posedge clk_sys or negedge rstN)
   begin
      if (!rstN)
      begin
         cnt_q <= 16'h0000;
         buf_q <= 2'h0;
      end
      else if (start && cnt_q == 16'h0000)
      begin
         cnt_q <= 16'(sfp_pkg::BUSY_CYCLES);
         buf_q <= bufSel;
      end
      else if (cnt_q != 16'h0000)
      begin
         cnt_q <= cnt_q - 16'h0001;
      end
   end

   assign busy = (cnt_q != 16'h0000);
   assign busyBuf = busy ? buf_q : 2'h0;

   property p_busy_len;
      @(posedge clk_sys) disable iff (!rstN)
      $rose(busy) |-> busy [*8];
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy too short");
endmodule

// [verilog/sfp_front_end.sv]
// Pin front end: frame, shift, write protect, busy and buffer gating
module sfp_front_end
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic csN,
   input wire logic sck,
   input wire logic si,
   output logic soOut,
   output logic soOe,
   input wire logic wpN,
   input wire logic resetPinN,
   output logic rdyBusyOut,
   output logic rdyBusyOe,
   output logic [7:0] cmdOpcode,
   output logic cmdStrobe,
   output logic cmdRejected,
   output logic arrayDenied,
   input wire logic [7:0] txByte,
   input wire logic [sfp_pkg::SECTOR_MSB:0] cmdSector,
   input wire logic [15:0] protMapIn,
   output logic [15:0] protMap
);
   // ----------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------
   logic [1:0] rstSync_q;
   logic rstN;
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         rstSync_q <= 2'h0;
      else
         rstSync_q <= {rstSync_q[0], 1'b1};
   end

   // Reset pin is synchronised; it holds the core in reset while low
   logic [1:0] pinRst_q;
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         pinRst_q <= 2'h0;
      else
         pinRst_q <= {pinRst_q[0], resetPinN};
   end
   assign rstN = rstSync_q[1] & pinRst_q[1];

   logic [1:0] csS_q, sckS_q, siS_q, wpS_q;
   logic sckPrev_q;
   always_ff @(posedge clk_sys or negedge rstN)
   begin
      if (!rstN)
      begin
         csS_q <= 2'h3;
         sckS_q <= 2'h0;
         siS_q <= 2'h0;
         wpS_q <= 2'h3;
         sckPrev_q <= 1'b0;
      end
      else
      begin
         csS_q <= {csS_q[0], csN};
         sckS_q <= {sckS_q[0], sck};
         siS_q <= {siS_q[0], si};
         wpS_q <= {wpS_q[0], wpN};
         sckPrev_q <= sckS_q[1];
      end
   end

   logic selected, sckRise, sckFall, wpOn;
   assign selected = !csS_q[1];
   assign sckRise = sckS_q[1] && !sckPrev_q;
   assign sckFall = !sckS_q[1] && sckPrev_q;
   assign wpOn = !wpS_q[1];

   logic csPrev_q;
   always_ff @(posedge clk_sys or negedge rstN)
   begin
      if (!rstN)
         csPrev_q <= 1'b1;
      else
         csPrev_q <= csS_q[1];
   end
   logic csFall, csRise;
   assign csFall = csPrev_q && !csS_q[1];
   assign csRise = !csPrev_q && csS_q[1];

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   function automatic logic isModify(input logic [7:0] op);
      return op == sfp_pkg::CMD_PROGRAM || op == sfp_pkg::CMD_ERASE;
   endfunction
   function automatic logic usesArray(input logic [7:0] op);
      return isModify(op) || op == sfp_pkg::CMD_READ_ARRAY || op == sfp_pkg::CMD_COMPARE
         || op == sfp_pkg::CMD_XFER;
   endfunction
   function automatic logic [1:0] bufOf(input logic [7:0] op);
      if (op == sfp_pkg::CMD_BUF1_WRITE || op == sfp_pkg::CMD_BUF1_READ)
         return 2'h1;
      if (op == sfp_pkg::CMD_BUF2_WRITE || op == sfp_pkg::CMD_BUF2_READ)
         return 2'h2;
      return 2'h0;
   endfunction

   // ----------------------------------------
   // Control state machine
   // ----------------------------------------
   sfp_pkg::sfp_state_t state_q;
   logic [3:0] bitCnt_q;
   logic [7:0] shift_q;
   logic [7:0] op_q;
   logic busy, startOp;
   logic [1:0] busyBuf;
   logic [7:0] opNext;
   logic opDone;
   assign opNext = {shift_q[6:0], siS_q[1]};
   assign opDone = selected && sckRise && bitCnt_q == sfp_pkg::OP_CNT_LAST;

   always_ff @(posedge clk_sys or negedge rstN)
   begin
      if (!rstN)
      begin
         state_q <= sfp_pkg::ST_IDLE;
         bitCnt_q <= 4'h0;
         shift_q <= 8'h00;
         op_q <= 8'h00;
      end
      else
      begin
         case (state_q)
            sfp_pkg::ST_IDLE:
               if (csFall)
               begin
                  state_q <= sfp_pkg::ST_OPCODE;
                  bitCnt_q <= 4'h0;
               end
            sfp_pkg::ST_OPCODE:
               if (!selected)
                  state_q <= sfp_pkg::ST_IDLE;
               else if (sckRise)
               begin
                  shift_q <= opNext;
                  bitCnt_q <= bitCnt_q + 4'h1;
                  if (opDone)
                  begin
                     op_q <= opNext;
                     if ((isModify(opNext) && wpOn) || (usesArray(opNext) && busy)
                        || (bufOf(opNext) != 2'h0 && bufOf(opNext) == busyBuf))
                        state_q <= sfp_pkg::ST_DISCARD;
                     else
                        state_q <= sfp_pkg::ST_ARG;
                  end
               end
            sfp_pkg::ST_ARG:
               if (csRise)
                  state_q <= (isModify(op_q) || op_q == sfp_pkg::CMD_COMPARE || op_q == sfp_pkg::CMD_XFER)
                     ? sfp_pkg::ST_BUSY : sfp_pkg::ST_IDLE;
            sfp_pkg::ST_DISCARD:
               if (!selected)
                  state_q <= sfp_pkg::ST_IDLE;
            sfp_pkg::ST_BUSY:
               if (csFall)
               begin
                  // The other buffer stays usable while the timer runs
                  state_q <= sfp_pkg::ST_OPCODE;
                  bitCnt_q <= 4'h0;
               end
               else if (!busy)
                  state_q <= sfp_pkg::ST_IDLE;
            default:
               state_q <= sfp_pkg::ST_IDLE;
         endcase
      end
   end
   assign startOp = (state_q == sfp_pkg::ST_ARG) && csRise
      && (isModify(op_q) || op_q == sfp_pkg::CMD_COMPARE || op_q == sfp_pkg::CMD_XFER);

   sfp_busy_timer u_timer
   (
      .clk_sys(clk_sys),
      .rstN(rstN),
      .start(startOp),
      .bufSel(op_q == sfp_pkg::CMD_XFER ? 2'h1 : 2'h0),
      .busy(busy),
      .busyBuf(busyBuf)
   );

   // Open drain: enable pulls low while self-timed work runs
   assign rdyBusyOut = 1'b0;
   assign rdyBusyOe = busy;

   logic strobe_q, rej_q, deny_q;
   always_ff @(posedge clk_sys or negedge rstN)
   begin
      if (!rstN)
      begin
         strobe_q <= 1'b0;
         rej_q <= 1'b0;
         deny_q <= 1'b0;
      end
      else
      begin
         strobe_q <= opDone && state_q == sfp_pkg::ST_OPCODE;
         rej_q <= opDone && state_q == sfp_pkg::ST_OPCODE && isModify(opNext) && wpOn;
         deny_q <= opDone && state_q == sfp_pkg::ST_OPCODE && usesArray(opNext) && busy;
      end
   end
   assign cmdStrobe = strobe_q;
   assign cmdRejected = rej_q;
   assign arrayDenied = deny_q;
   assign cmdOpcode = op_q;

   // ----------------------------------------
   // Sector protection map
   // ----------------------------------------
   logic [15:0] prot_q;
   always_ff @(posedge clk_sys or negedge rstN)
   begin
      if (!rstN)
         prot_q <= sfp_pkg::PROT_MAP_RST;
      else if (state_q == sfp_pkg::ST_ARG && csRise && op_q == sfp_pkg::CMD_PROT_WRITE && !wpOn)
         prot_q <= protMapIn;
      else if (state_q == sfp_pkg::ST_ARG && csRise && op_q == sfp_pkg::CMD_LOCKDOWN)
         prot_q <= prot_q | (16'h0001 << cmdSector);
   end
   assign protMap = prot_q;

   // ----------------------------------------
   // Serial output
   // ----------------------------------------
   logic [7:0] tx_q;
   logic so_q;
   logic [2:0] txCnt_q;
   always_ff @(posedge clk_sys or negedge rstN)
   begin
      if (!rstN)
      begin
         tx_q <= 8'h00;
         so_q <= 1'b0;
         txCnt_q <= 3'h0;
      end
      else if (!selected)
         txCnt_q <= 3'h0;
      else if (state_q == sfp_pkg::ST_ARG && sckFall)
      begin
         so_q <= (txCnt_q == 3'h0) ? txByte[7] : tx_q[7];
         tx_q <= (txCnt_q == 3'h0) ? {txByte[6:0], 1'b0} : {tx_q[6:0], 1'b0};
         txCnt_q <= txCnt_q + 3'h1;
      end
   end
   assign soOut = so_q;
   assign soOe = selected && state_q == sfp_pkg::ST_ARG;

   property p_wp_reject;
      @(posedge clk_sys) disable iff (!rstN)
      (opDone && state_q == sfp_pkg::ST_OPCODE && isModify(opNext) && wpOn) |=> state_q == sfp_pkg::ST_DISCARD;
   endproperty
   a_wp_reject: assert property (p_wp_reject) else $error("protected modify accepted");
   property p_idle_desel;
      @(posedge clk_sys) disable iff (!rstN)
      (state_q == sfp_pkg::ST_DISCARD && !selected) |=> state_q == sfp_pkg::ST_IDLE;
   endproperty
   a_idle_desel: assert property (p_idle_desel) else $error("discard not ended");
   property p_prot_frozen;
      @(posedge clk_sys) disable iff (!rstN)
      (wpOn && $past(wpOn) && op_q != sfp_pkg::CMD_LOCKDOWN) |-> $stable(prot_q);
   endproperty
   a_prot_frozen: assert property (p_prot_frozen) else $error("map changed under protect");
   property p_hiz;
      @(posedge clk_sys) disable iff (!rstN)
      !selected |-> !soOe;
   endproperty
   a_hiz: assert property (p_hiz) else $error("output driven deselected");
   property p_busy_pin;
      @(posedge clk_sys) disable iff (!rstN)
      startOp |=> rdyBusyOe [*4];
   endproperty
   a_busy_pin: assert property (p_busy_pin) else $error("busy not shown");
   property p_standby;
      @(posedge clk_sys) disable iff (!rstN)
      (state_q == sfp_pkg::ST_BUSY && busy && !csFall) |=> state_q == sfp_pkg::ST_BUSY;
   endproperty
   a_standby: assert property (p_standby) else $error("left busy early");
   property p_sample;
      @(posedge clk_sys) disable iff (!rstN)
      (state_q == sfp_pkg::ST_OPCODE && selected && sckRise) |=> shift_q[0] == $past(siS_q[1]);
   endproperty
   a_sample: assert property (p_sample) else $error("bit not sampled");
   property p_deny;
      @(posedge clk_sys) disable iff (!rstN)
      (opDone && state_q == sfp_pkg::ST_OPCODE && usesArray(opNext) && busy) |=> arrayDenied;
   endproperty
   a_deny: assert property (p_deny) else $error("array access not denied");
   c_reject: cover property (@(posedge clk_sys) disable iff (!rstN) cmdRejected);
   c_busy: cover property (@(posedge clk_sys) disable iff (!rstN) startOp);
   c_lock: cover property (@(posedge clk_sys) disable iff (!rstN) $changed(prot_q));
endmodule

// [verilog/sfp_pkg.sv]
// Package of constants for the serial flash pin front end
// Contract
// - Sample input bits on serial clock rise
// - Update output bit on serial clock fall
// - Write protect blocks flagged sector program/erase; code blocks every program/erase while low, ignoring the map
// - Write protect low freezes protection map; code still lets lockdown set a sector's map bit while low
// - Protected program/erase discarded, idle at deselect
// - Arm and lockdown commands still run under protect
// - Write protect reads inactive when unconnected
// - Reset low aborts work, idles state machine
// - Stay reset while reset low
// - Internal power-on reset, no sequencing needed
// - Busy pulls ready/busy low, else released
// - Busy denies array and engaged buffer only
// - Chip select fall starts, rise ends operation
// - Deselected: output high impedance, input ignored
// - Self-timed work outlives deselect, then standby
package sfp_pkg;
   // ----------------------------------------
   // Command codes (arbitrary internal encoding)
   // ----------------------------------------
   localparam logic [7:0] CMD_READ_ARRAY = 8'h0B;
   localparam logic [7:0] CMD_PROGRAM = 8'h82;
   localparam logic [7:0] CMD_ERASE = 8'h81;
   localparam logic [7:0] CMD_COMPARE = 8'h60;
   localparam logic [7:0] CMD_XFER = 8'h53;
   localparam logic [7:0] CMD_PROT_WRITE = 8'h3D;
   localparam logic [7:0] CMD_PROT_ARM = 8'h3F;
   localparam logic [7:0] CMD_LOCKDOWN = 8'h30;
   localparam logic [7:0] CMD_BUF1_WRITE = 8'h84;
   localparam logic [7:0] CMD_BUF2_WRITE = 8'h87;
   localparam logic [7:0] CMD_BUF1_READ = 8'hD4;
   localparam logic [7:0] CMD_BUF2_READ = 8'hD6;
   // ----------------------------------------
   // Geometry and timing
   // ----------------------------------------
   localparam int SECTORS = 16;
   localparam int SECTOR_MSB = 3;
   localparam int OP_BITS = 8;
   localparam logic [3:0] OP_CNT_LAST = 4'h7;
   localparam int BUSY_TIME_NS = 400;
   localparam int CLK_PERIOD_NS = 4;
   localparam int BUSY_CYCLES = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [SECTORS-1:0] PROT_MAP_RST = 16'h0000;
   typedef enum logic [2:0] {ST_IDLE, ST_OPCODE, ST_ARG, ST_DISCARD, ST_BUSY} sfp_state_t;
endpackage
